/* shared/bcpr_cfg.svh */
// Offsets, field positions, reset values and decode constants of the bridge slice
`ifndef BCPR_CFG_SVH
`define BCPR_CFG_SVH
// Register indices; byte address is four times the index
`define BCPR_IDX_PIN 8'h3d
`define BCPR_IDX_BRIDGE_CONTROL 8'h3e
`define BCPR_IDX_CAP 8'h40
`define BCPR_ADDR_W 10
// Interrupt pin selector
`define BCPR_PIN_RST 8'h00
`define BCPR_PIN_MAX 8'h04
// Bridge control bit positions
`define BCPR_B_POISON 0
`define BCPR_B_ERRFWD 1
`define BCPR_B_ISA 2
`define BCPR_B_VGA 3
`define BCPR_B_VGA16 4
`define BCPR_B_SBR 6
`define BCPR_BRIDGE_CONTROL_RST 16'h0000
`define BCPR_BRIDGE_CONTROL_MASK 16'h005f
// Capability dword fields and reset values
`define BCPR_CAP_ID 8'h10
`define BCPR_NXT_RST 8'hc0
`define BCPR_VER_RST 4'h1
`define BCPR_TYPE_UP 4'h5
`define BCPR_TYPE_DN 4'h6
`define BCPR_MSI_NUM 5'h00
`define BCPR_TCS_RST 1'b1
// Legacy I/O decode constants
`define BCPR_ISA_TOP 16'h0000
`define BCPR_VGA_A_LO 10'h3b0
`define BCPR_VGA_A_HI 10'h3bb
`define BCPR_VGA_B_LO 10'h3c0
`define BCPR_VGA_B_HI 10'h3df
`endif

/* shared/bcpr_pkg.sv */
// Types shared by the bridge control and capability slice
package bcpr_pkg;
   // APB slave phase
   typedef enum logic {BCPR_IDLE, BCPR_ACC} bcpr_apb_e;
   typedef logic [31:0] bcpr_word_t;
endpackage

/* verilog/bcpr_regs.sv */
// Bridge control, interrupt pin and express capability registers behind APB
//
// Notes on behaviour
// [RL1] Pin selector: 0 no interrupt, 1..4 select INTA..INTD.
// [RL2] Software writes only 0..4 into the pin selector.
// [RL3] Pin selector resets to zero; no legacy interrupt by default.
// [RL4] Poison bit clear ignores secondary poisoned TLPs, set reports them.
// [RL5] Error forward bit lets secondary fatal/non-fatal errors pass upstream.
// [RL6] Forwarded errors reported only with command or device reporting enabled.
// [RL7] ISA bit clear: forward every in-window I/O address downstream.
// [RL8] ISA bit set: top 768 bytes per 1 KB below 64 KB go upstream.
// [RL9] VGA bit set forwards VGA addresses downstream; clear blocks them.
// [RL10] VGA width bit matters only while VGA forwarding is set.
// [RL11] Width bit clear: 10-bit aliased decode; set: full 16-bit decode.
// [RL12] Secondary reset bit starts a secondary bus reset.
// [RL13] Capability ID reads fixed 0x10.
// [RL14] Next pointer resets to 0xc0.
// [RL15] Version field resets to 0x1.
// [RL16] Port type reads 0x5 upstream, 0x6 downstream.
// [RL17] Slot bit marks a slot link; software keeps it zero upstream.
// [RL18] MSI number reads zero.
// [RL19] Traffic class routing bit resets to one.
// [RL20] Reserved bits read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none
`include "bcpr_cfg.svh"

module bcpr_regs #(
   parameter int IO_W = 32
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`BCPR_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Port strap, sampled after reset release
   input wire logic upstream_port_i,
   // Error reporting enables from neighbouring registers
   input wire logic cmd_serr_en_i,
   input wire logic dev_err_report_en_i,
   // Secondary side events
   input wire logic sec_poison_tlp_i,
   input wire logic sec_err_msg_i,
   // I/O request to route
   input wire logic io_req_i,
   input wire logic [IO_W-1:0] io_addr_i,
   input wire logic [IO_W-1:0] io_base_i,
   input wire logic [IO_W-1:0] io_limit_i,
   // Routing and event results
   output logic io_fwd_down_o,
   output logic io_fwd_up_o,
   output logic vga_fwd_down_o,
   output logic poison_report_o,
   output logic err_fwd_o,
   output logic err_report_o,
   // Control levels
   output logic secondary_bus_reset_o,
   output logic [7:0] legacy_irq_pin_sel_o
);

   // Register state
   logic [7:0] legacy_irq_pin_sel;
   logic [15:0] bridge_control_word;
   logic [7:0] next_capability_pointer;
   logic [3:0] capability_version;
   logic slot_implemented;
   logic traffic_class_routing;
   logic strap_done;
   logic is_upstream;
   bcpr_pkg::bcpr_apb_e apb_state;
   logic [7:0] next_legacy_irq_pin_sel;
   logic [15:0] next_bridge_control_word;
   logic [7:0] next_next_capability_pointer;
   logic [3:0] next_capability_version;
   logic next_slot_implemented;
   logic next_traffic_class_routing;
   logic next_strap_done;
   logic next_is_upstream;
   bcpr_pkg::bcpr_apb_e next_apb_state;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   // Routing state
   logic next_io_fwd_down;
   logic next_io_fwd_up;
   logic next_vga_fwd_down;
   logic next_poison_report;
   logic next_err_fwd;
   logic next_err_report;

   // Decode helpers
   logic sel_pin;
   logic sel_bridge_control;
   logic sel_cap;
   logic mapped;
   logic wr_now;
   logic [3:0] port_type;
   bcpr_pkg::bcpr_word_t cap_word;
   bcpr_pkg::bcpr_word_t rd_word;

   // Register address decode, byte address is index times four
   always_comb begin
      sel_pin = (paddr == {`BCPR_IDX_PIN, 2'b00});
      sel_bridge_control = (paddr == {`BCPR_IDX_BRIDGE_CONTROL, 2'b00});
      sel_cap = (paddr == {`BCPR_IDX_CAP, 2'b00});
      mapped = sel_pin | sel_bridge_control | sel_cap;
      wr_now = psel & penable & pready & pwrite;
   end

   // Capability dword assembly
   always_comb begin
      port_type = is_upstream ? `BCPR_TYPE_UP : `BCPR_TYPE_DN; // RL16
      cap_word = '0; // RL20
      cap_word[7:0] = `BCPR_CAP_ID; // RL13
      cap_word[15:8] = next_capability_pointer; // RL14
      cap_word[19:16] = capability_version; // RL15
      cap_word[23:20] = port_type; // RL16
      cap_word[24] = slot_implemented; // RL17
      cap_word[29:25] = `BCPR_MSI_NUM; // RL18
      cap_word[30] = traffic_class_routing; // RL19
   end

   // Read mux, narrow registers sit in the low bits
   always_comb begin
      rd_word = '0;
      if (sel_pin) begin
         rd_word[7:0] = legacy_irq_pin_sel;
      end
      if (sel_bridge_control) begin
         rd_word[15:0] = bridge_control_word & `BCPR_BRIDGE_CONTROL_MASK; // RL20
      end
      if (sel_cap) begin
         rd_word = cap_word;
      end
   end

   // APB handshake: one setup cycle, one access cycle with pready
   always_comb begin
      next_apb_state = apb_state;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_prdata = prdata;
      unique case (apb_state)
         bcpr_pkg::BCPR_IDLE: begin
            if (psel && !penable) begin
               next_apb_state = bcpr_pkg::BCPR_ACC;
               next_pready = 1'b1;
               next_pslverr = !mapped;
               next_prdata = (!pwrite && mapped) ? rd_word : 32'h0000_0000;
            end
         end
         bcpr_pkg::BCPR_ACC: begin
            next_apb_state = bcpr_pkg::BCPR_IDLE;
         end
      endcase
   end

   // Register writes with byte strobes, taken on the completing edge
   always_comb begin
      next_legacy_irq_pin_sel = legacy_irq_pin_sel;
      next_bridge_control_word = bridge_control_word;
      next_next_capability_pointer = next_capability_pointer;
      next_capability_version = capability_version;
      next_slot_implemented = slot_implemented;
      next_traffic_class_routing = traffic_class_routing;
      if (wr_now && !pslverr) begin
         if (sel_pin && pstrb[0]) begin
            next_legacy_irq_pin_sel = pwdata[7:0]; // RL1
         end
         if (sel_bridge_control && pstrb[0]) begin
            next_bridge_control_word[7:0] = pwdata[7:0] & 8'(`BCPR_BRIDGE_CONTROL_MASK); // RL20
         end
         if (sel_cap && pstrb[1]) begin
            next_next_capability_pointer = pwdata[15:8]; // RL14
         end
         if (sel_cap && pstrb[2]) begin
            next_capability_version = pwdata[19:16]; // RL15
         end
         if (sel_cap && pstrb[3]) begin
            next_slot_implemented = pwdata[24]; // RL17
            next_traffic_class_routing = pwdata[30]; // RL19
         end
      end
   end

   // Port strap caught once after reset release
   always_comb begin
      next_strap_done = 1'b1;
      next_is_upstream = strap_done ? is_upstream : upstream_port_i; // RL16
   end

   // Legacy I/O routing and secondary events
   logic in_window;
   logic isa_hit;
   logic vga_hit;
   logic [9:0] alias_addr;
   always_comb begin
      alias_addr = io_addr_i[9:0];
      in_window = (io_addr_i >= io_base_i) && (io_addr_i <= io_limit_i);
      // Below 64 KB and in the upper 768 bytes of a 1 KB block
      isa_hit = (io_addr_i[IO_W-1:16] == '0) && (io_addr_i[9:8] != 2'b00); // RL8
      vga_hit = ((alias_addr >= `BCPR_VGA_A_LO) && (alias_addr <= `BCPR_VGA_A_HI))
         || ((alias_addr >= `BCPR_VGA_B_LO) && (alias_addr <= `BCPR_VGA_B_HI));
      if (bridge_control_word[`BCPR_B_VGA16]) begin
         vga_hit = vga_hit && (io_addr_i[15:10] == 6'h00); // RL11
      end
      next_vga_fwd_down = io_req_i && bridge_control_word[`BCPR_B_VGA] && vga_hit; // RL9 RL10
      next_io_fwd_up = io_req_i && in_window && bridge_control_word[`BCPR_B_ISA]
         && isa_hit; // RL8
      next_io_fwd_down = io_req_i && in_window && !next_vga_fwd_down
         && !(bridge_control_word[`BCPR_B_ISA] && isa_hit); // RL7
      next_poison_report = sec_poison_tlp_i
         && bridge_control_word[`BCPR_B_POISON]; // RL4
      next_err_fwd = sec_err_msg_i && bridge_control_word[`BCPR_B_ERRFWD]; // RL5
      next_err_report = next_err_fwd
         && (cmd_serr_en_i || dev_err_report_en_i); // RL6
   end

   // Register all state and outputs
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         legacy_irq_pin_sel <= `BCPR_PIN_RST; // RL3
         bridge_control_word <= `BCPR_BRIDGE_CONTROL_RST;
         next_capability_pointer <= `BCPR_NXT_RST; // RL14
         capability_version <= `BCPR_VER_RST; // RL15
         slot_implemented <= 1'b0;
         traffic_class_routing <= `BCPR_TCS_RST; // RL19
         strap_done <= 1'b0;
         is_upstream <= 1'b0;
         apb_state <= bcpr_pkg::BCPR_IDLE;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         io_fwd_down_o <= 1'b0;
         io_fwd_up_o <= 1'b0;
         vga_fwd_down_o <= 1'b0;
         poison_report_o <= 1'b0;
         err_fwd_o <= 1'b0;
         err_report_o <= 1'b0;
         secondary_bus_reset_o <= 1'b0;
         legacy_irq_pin_sel_o <= `BCPR_PIN_RST;
      end else begin
         legacy_irq_pin_sel <= next_legacy_irq_pin_sel;
         bridge_control_word <= next_bridge_control_word;
         next_capability_pointer <= next_next_capability_pointer;
         capability_version <= next_capability_version;
         slot_implemented <= next_slot_implemented;
         traffic_class_routing <= next_traffic_class_routing;
         strap_done <= next_strap_done;
         is_upstream <= next_is_upstream;
         apb_state <= next_apb_state;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         io_fwd_down_o <= next_io_fwd_down;
         io_fwd_up_o <= next_io_fwd_up;
         vga_fwd_down_o <= next_vga_fwd_down;
         poison_report_o <= next_poison_report;
         err_fwd_o <= next_err_fwd;
         err_report_o <= next_err_report;
         secondary_bus_reset_o <= next_bridge_control_word[`BCPR_B_SBR]; // RL12
         legacy_irq_pin_sel_o <= next_legacy_irq_pin_sel; // RL1
      end
   end

   // Checks on the register slice
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   a_pin_write_value: assert property ( // RL1
      wr_now && !pslverr && sel_pin && pstrb[0]
      |=> legacy_irq_pin_sel_o == $past(pwdata[7:0]))
      else $error("Pin selector did not take written value");

   a_pin_reset_zero: assert property ( // RL3
      $rose(rst_b_i) |-> legacy_irq_pin_sel_o == `BCPR_PIN_RST)
      else $error("Pin selector not zero after reset");

   a_poison_gate: assert property ( // RL4
      sec_poison_tlp_i |=> poison_report_o == $past(bridge_control_word[`BCPR_B_POISON]))
      else $error("Poison report does not follow enable");

   a_err_forward: assert property ( // RL5
      sec_err_msg_i |=> err_fwd_o == $past(bridge_control_word[`BCPR_B_ERRFWD]))
      else $error("Error forward does not follow enable");

   a_err_report_gate: assert property ( // RL6
      err_report_o |-> err_fwd_o && ($past(cmd_serr_en_i) || $past(dev_err_report_en_i)))
      else $error("Error reported without reporting enable");

   a_isa_clear_down: assert property ( // RL7
      io_req_i && in_window && !vga_hit && !bridge_control_word[`BCPR_B_ISA]
      |=> io_fwd_down_o && !io_fwd_up_o)
      else $error("In-window I/O not forwarded downstream");

   a_isa_upstream: assert property ( // RL8
      io_fwd_up_o |-> $past(isa_hit) && $past(in_window) && $past(bridge_control_word[`BCPR_B_ISA]))
      else $error("Upstream forward outside ISA range");

   a_vga_blocked: assert property ( // RL9
      !bridge_control_word[`BCPR_B_VGA] |=> !vga_fwd_down_o)
      else $error("VGA forwarded while blocked");

   a_vga_wide_alias: assert property ( // RL11
      io_req_i && bridge_control_word[`BCPR_B_VGA] && bridge_control_word[`BCPR_B_VGA16]
      && io_addr_i[15:10] != 6'h00 |=> !vga_fwd_down_o)
      else $error("16-bit decode let an alias through");

   a_sbr_follows: assert property ( // RL12
      wr_now && !pslverr && sel_bridge_control && pstrb[0]
      |=> secondary_bus_reset_o == $past(pwdata[`BCPR_B_SBR]))
      else $error("Secondary reset does not follow control bit");

   a_cap_fixed: assert property ( // RL13
      sel_cap |-> cap_word[7:0] == `BCPR_CAP_ID && cap_word[29:25] == `BCPR_MSI_NUM
      && cap_word[31] == 1'b0)
      else $error("Capability fixed fields wrong");

   a_port_type: assert property ( // RL16
      $rose(strap_done) |-> port_type == ($past(upstream_port_i) ? `BCPR_TYPE_UP : `BCPR_TYPE_DN))
      else $error("Port type wrong");

   a_apb_one_wait: assert property ( // APB handshake: pready in the access cycle only
      psel && !penable && !pready |=> pready ##1 !pready)
      else $error("APB answer not in access cycle");

   a_bridge_control_reserved: assert property ( // RL20
      (bridge_control_word & ~`BCPR_BRIDGE_CONTROL_MASK) == 16'h0000)
      else $error("Reserved control bits set");

   c_vga_fwd: cover property (vga_fwd_down_o);
   c_isa_up: cover property (io_fwd_up_o);
   c_err_report: cover property (err_report_o);
   c_bad_addr: cover property (pready && pslverr);

endmodule

`default_nettype wire

/* tb/test_bcpr_regs.sv */
// Self-checking bench for the bridge control and express capability register slice
`timescale 1ns/10ps
`default_nettype none
`include "bcpr_cfg.svh"

module test_bcpr_regs;
   // One routing or event case: control byte, I/O address, inputs, expected outputs
   typedef struct packed {
      logic [7:0] ctl;
      logic [31:0] addr;
      logic [4:0] ev;
      logic [5:0] exp;
   } bcpr_row_s;

   localparam logic [9:0] A_PIN = {`BCPR_IDX_PIN, 2'b00};
   localparam logic [9:0] A_BRIDGE_CONTROL = {`BCPR_IDX_BRIDGE_CONTROL, 2'b00};
   localparam logic [9:0] A_CAP = {`BCPR_IDX_CAP, 2'b00};
   localparam logic [9:0] A_BAD = 10'h004;
   localparam logic [31:0] CAP_UP = {1'b0, `BCPR_TCS_RST, `BCPR_MSI_NUM, 1'b0, `BCPR_TYPE_UP,
      `BCPR_VER_RST, `BCPR_NXT_RST, `BCPR_CAP_ID};
   localparam logic [31:0] CAP_DN = {1'b0, `BCPR_TCS_RST, `BCPR_MSI_NUM, 1'b0, `BCPR_TYPE_DN,
      `BCPR_VER_RST, `BCPR_NXT_RST, `BCPR_CAP_ID};
   localparam logic [31:0] CAP_ALL = {8'h41, `BCPR_TYPE_UP, 4'hf, 8'hff, `BCPR_CAP_ID};

   // Design ports
   logic core_clk_i, rst_b_i, psel, penable, pwrite, pready, pslverr;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata, io_addr_i, io_base_i, io_limit_i;
   logic [3:0] pstrb;
   logic upstream_port_i, cmd_serr_en_i, dev_err_report_en_i;
   logic sec_poison_tlp_i, sec_err_msg_i, io_req_i;
   logic io_fwd_down_o, io_fwd_up_o, vga_fwd_down_o, poison_report_o, err_fwd_o, err_report_o;
   logic secondary_bus_reset_o;
   logic [7:0] legacy_irq_pin_sel_o;
   wire [5:0] route_out;
   int bad_count = 0;
   int n_compared = 0;
   logic [31:0] rd;
   logic err;

   // Window 0x1000..0x1fff; rows exercise window, ISA, VGA and event paths
   bcpr_row_s rows [18] = '{
      '{8'h00, 32'h0000_1100, 5'h10, 6'h20}, '{8'h04, 32'h0000_1100, 5'h10, 6'h10},
      '{8'h04, 32'h0000_1010, 5'h10, 6'h20}, '{8'h00, 32'h0000_2100, 5'h10, 6'h00},
      '{8'h08, 32'h0000_03c0, 5'h10, 6'h08}, '{8'h08, 32'h0000_13c0, 5'h10, 6'h08},
      '{8'h18, 32'h0000_13c0, 5'h10, 6'h20}, '{8'h18, 32'h0000_03b4, 5'h10, 6'h08},
      '{8'h08, 32'h0000_03bc, 5'h10, 6'h00}, '{8'h08, 32'h0000_03df, 5'h10, 6'h08},
      '{8'h10, 32'h0000_03c0, 5'h10, 6'h00}, '{8'h00, 32'h0000_1fff, 5'h10, 6'h20},
      '{8'h00, 32'h0000_0fff, 5'h10, 6'h00}, '{8'h00, 32'h0000_0000, 5'h0e, 6'h00},
      '{8'h01, 32'h0000_0000, 5'h08, 6'h04}, '{8'h02, 32'h0000_0000, 5'h04, 6'h02},
      '{8'h02, 32'h0000_0000, 5'h06, 6'h03}, '{8'h02, 32'h0000_0000, 5'h05, 6'h03}};

   assign route_out = {io_fwd_down_o, io_fwd_up_o, vga_fwd_down_o, poison_report_o,
      err_fwd_o, err_report_o};

   bcpr_regs #(.IO_W(32)) dut (
      .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .upstream_port_i(upstream_port_i),
      .cmd_serr_en_i(cmd_serr_en_i), .dev_err_report_en_i(dev_err_report_en_i),
      .sec_poison_tlp_i(sec_poison_tlp_i), .sec_err_msg_i(sec_err_msg_i),
      .io_req_i(io_req_i), .io_addr_i(io_addr_i), .io_base_i(io_base_i),
      .io_limit_i(io_limit_i), .io_fwd_down_o(io_fwd_down_o), .io_fwd_up_o(io_fwd_up_o),
      .vga_fwd_down_o(vga_fwd_down_o), .poison_report_o(poison_report_o),
      .err_fwd_o(err_fwd_o), .err_report_o(err_report_o),
      .secondary_bus_reset_o(secondary_bus_reset_o),
      .legacy_irq_pin_sel_o(legacy_irq_pin_sel_o));

   // Clock at 100 MHz
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   // Word compare
   task automatic chk_w(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Flag compare
   task automatic chk_b(input string name, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %b seen %b", name, exp, got);
      end
   endtask

   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d,
         input logic [3:0] s, output logic [31:0] q, output logic e);
      int n;
      @(posedge core_clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      e = pslverr;
      if (n >= 16) chk_b("pready", 1'b1, 1'b0);
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the completing edge settle before outputs are compared
      #1;
   endtask

   // Reset pulse with the port strap set before release
   task automatic do_reset(input logic up);
      rst_b_i <= 1'b0;
      upstream_port_i <= up;
      repeat (5) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
   endtask

   // Verdict and end of run
   task automatic complete_run();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      #200000;
      bad_count++;
      complete_run();
   end

   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {cmd_serr_en_i, dev_err_report_en_i, sec_poison_tlp_i, sec_err_msg_i, io_req_i} = '0;
      io_addr_i = 32'h0;
      io_base_i = 32'h0000_1000;
      io_limit_i = 32'h0000_1fff;
      rst_b_i = 1'b0;
      upstream_port_i = 1'b1;
      do_reset(1'b1);
      apb(1'b0, A_PIN, 32'h0, 4'hf, rd, err);
      chk_w("pin reset", 32'h0, rd);
      chk_w("pin out reset", 32'h0, {24'h0, legacy_irq_pin_sel_o});
      apb(1'b0, A_BRIDGE_CONTROL, 32'h0, 4'hf, rd, err);
      chk_w("bridge_control reset", {16'h0, `BCPR_BRIDGE_CONTROL_RST}, rd);
      apb(1'b0, A_CAP, 32'h0, 4'hf, rd, err);
      chk_w("cap up", CAP_UP, rd);
      chk_b("slverr ok", 1'b0, err);
      // Routing and event table
      foreach (rows[i]) begin
         apb(1'b1, A_BRIDGE_CONTROL, {24'h0, rows[i].ctl}, 4'hf, rd, err);
         @(posedge core_clk_i);
         {io_req_i, sec_poison_tlp_i, sec_err_msg_i, cmd_serr_en_i, dev_err_report_en_i}
            <= rows[i].ev;
         io_addr_i <= rows[i].addr;
         @(posedge core_clk_i);
         {io_req_i, sec_poison_tlp_i, sec_err_msg_i} <= 3'h0;
         #1;
         chk_w("route", {26'h0, rows[i].exp}, {26'h0, route_out});
         @(posedge core_clk_i);
         #1;
         chk_w("route idle", 32'h0, {26'h0, route_out});
      end
      // Pin selector codes, software keeps to 0..4
      for (int v = 0; v < 5; v++) begin
         apb(1'b1, A_PIN, v, 4'hf, rd, err);
         apb(1'b0, A_PIN, 32'h0, 4'hf, rd, err);
         chk_w("pin", v, rd);
         chk_w("pin out", v, {24'h0, legacy_irq_pin_sel_o});
      end
      // Reserved control bits and secondary bus reset level
      apb(1'b1, A_BRIDGE_CONTROL, 32'hffff_ffff, 4'hf, rd, err);
      apb(1'b0, A_BRIDGE_CONTROL, 32'h0, 4'hf, rd, err);
      chk_w("bridge_control rsvd", {16'h0, `BCPR_BRIDGE_CONTROL_MASK}, rd);
      chk_b("sbr set", 1'b1, secondary_bus_reset_o);
      apb(1'b1, A_BRIDGE_CONTROL, 32'h0, 4'h0, rd, err);
      chk_b("sbr strobe", 1'b1, secondary_bus_reset_o);
      apb(1'b1, A_BRIDGE_CONTROL, 32'h0, 4'hf, rd, err);
      chk_b("sbr clear", 1'b0, secondary_bus_reset_o);
      // Capability writes: fixed fields hold, strobes select lanes
      apb(1'b1, A_CAP, 32'hffff_ffff, 4'hf, rd, err);
      apb(1'b0, A_CAP, 32'h0, 4'hf, rd, err);
      chk_w("cap ones", CAP_ALL, rd);
      apb(1'b1, A_CAP, 32'h0, 4'h2, rd, err);
      apb(1'b0, A_CAP, 32'h0, 4'hf, rd, err);
      chk_w("cap lane", CAP_ALL & 32'hffff_00ff, rd);
      // Unmapped address refused
      apb(1'b0, A_BAD, 32'h0, 4'hf, rd, err);
      chk_b("slverr rd", 1'b1, err);
      chk_w("bad rd", 32'h0, rd);
      apb(1'b1, A_BAD, 32'hffff_ffff, 4'hf, rd, err);
      chk_b("slverr wr", 1'b1, err);
      apb(1'b0, A_PIN, 32'h0, 4'hf, rd, err);
      chk_w("pin kept", 32'h4, rd);
      // Mid-run reset as a downstream port
      do_reset(1'b0);
      apb(1'b0, A_CAP, 32'h0, 4'hf, rd, err);
      chk_w("cap dn", CAP_DN, rd);
      apb(1'b0, A_PIN, 32'h0, 4'hf, rd, err);
      chk_w("pin reset 2", 32'h0, rd);
      chk_b("sbr reset", 1'b0, secondary_bus_reset_o);
      complete_run();
   end
endmodule
`default_nettype wire
